// >>> design/fsp_pkg.sv
// Constants, register map and state types of the four-mode serial port.
// Assumes a 100 MHz core clock that also serves as the oscillator clock.
package fsp_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL  = 8'h98;
  localparam logic [7:0] ADDR_DBUF  = 8'h9C;
  localparam logic [7:0] ADDR_AUX   = 8'hA0;
  // Control register bits
  localparam int B_MODE_HI = 7;
  localparam int B_MODE_LO = 6;
  localparam int B_FILT    = 5;
  localparam int B_REN     = 4;
  localparam int B_TB8     = 3;
  localparam int B_RB8     = 2;
  localparam int B_TI      = 1;
  localparam int B_RI      = 0;
  // Auxiliary register bits
  localparam int B_DBL     = 0;
  localparam int B_RCS     = 1;
  localparam int B_TCS     = 2;
  localparam int B_TXACT   = 4;
  localparam int B_RXACT   = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] AUX_RST  = 3'h0;
  // Modes
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_U8    = 2'h1;
  localparam logic [1:0] MODE_U9F   = 2'h2;
  localparam logic [1:0] MODE_U9V   = 2'h3;
  // Machine cycle phases, T1 = 0
  localparam logic [3:0] PH_T1  = 4'h0;
  localparam logic [3:0] PH_T4  = 4'h3;
  localparam logic [3:0] PH_T5  = 4'h4;
  localparam logic [3:0] PH_T10 = 4'h9;
  localparam logic [3:0] PH_T11 = 4'hA;
  localparam logic [3:0] PH_T12 = 4'hB;
  // Bit timing
  localparam logic [3:0] C16_LAST = 4'hF;
  localparam logic [3:0] SAMP_A   = 4'h7;
  localparam logic [3:0] SAMP_B   = 4'h8;
  localparam logic [3:0] SAMP_C   = 4'h9;
  localparam logic [1:0] M2_DIV_SLOW = 2'h3;
  localparam logic [1:0] M2_DIV_FAST = 2'h1;
  localparam logic [3:0] IDX_LAST_U8 = 4'h9;
  localparam logic [3:0] IDX_LAST_U9 = 4'hA;
  localparam logic [3:0] IDX_RX_LAST = 4'h9;
  localparam logic [8:0] RX0_INIT = 9'h1FE;
  localparam logic [8:0] RXU_INIT = 9'h1FF;
  localparam logic [8:0] TX0_DONE = 9'h001;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Gray-coded states
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_ARM = 2'h1, TX_SEND = 2'h3, TX_FIN = 2'h2} fsp_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_ARM = 2'h1, RX_BUSY = 2'h3} fsp_rx_st_t;
endpackage

// >>> design/fsp_serial_port.sv
// Four-mode serial port with AXI4-Lite register access.
// Assumes all inputs synchronous to i_ref_clk; overflow inputs are one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module fsp_serial_port (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // AXI4-Lite write
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Timer overflow strobes
  input  wire logic        i_tmr1_ovf,
  input  wire logic        i_tmr2_ovf,
  // Serial pins
  input  wire logic        i_port_three_bit_zero,
  output logic             o_port_three_bit_zero,
  output logic             o_port_three_bit_zero_oe_n,
  output logic             o_port_three_bit_one,
  // Interrupt request
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic                awrdy;
    logic                wrdy;
    logic                aw_hold;
    logic                w_hold;
    logic [7:0]          awaddr;
    logic [7:0]          wdata;
    logic                wstb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arrdy;
    logic                rvalid;
    logic [7:0]          rdata;
    logic [1:0]          rresp;
    logic [7:0]          ctrl;
    logic [7:0]          rbuf;
    logic [2:0]          aux;
    logic [3:0]          phase;
    logic [1:0]          mdiv;
    logic                half1;
    logic                half2;
    fsp_pkg::fsp_tx_st_t tx_st;
    logic [3:0]          tx_c16;
    logic [9:0]          tsr;
    logic [3:0]          tx_idx;
    logic                m0w;
    fsp_pkg::fsp_rx_st_t rx_st;
    logic [3:0]          rx_c16;
    logic [8:0]          rsr;
    logic [3:0]          rx_idx;
    logic                rx_prev;
    logic [1:0]          votes;
    logic                samp;
    logic                txd;
    logic                rxo;
    logic                rxoe_n;
    logic                irq;
  } fsp_state_t;

  fsp_state_t s_q;
  fsp_state_t s_d;

  logic [1:0] mode;
  logic       wr_go;
  logic       wr_ctrl;
  logic       wr_dbuf;
  logic       m2_tick;
  logic       t1_tick;
  logic       t2_tick;
  logic       rx_tick;
  logic       tx_tick;
  logic       tx_bit;
  logic       maj;
  logic       rxd;
  logic       shclk;
  logic [3:0] tx_last;
  logic [8:0] rsr_sh;

  assign mode = s_q.ctrl[fsp_pkg::B_MODE_HI:fsp_pkg::B_MODE_LO];
  assign rxd  = i_port_three_bit_zero;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Bus write decode
    wr_go   = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
    wr_ctrl = wr_go && s_q.wstb && (s_q.awaddr == fsp_pkg::ADDR_CTRL);
    wr_dbuf = wr_go && s_q.wstb && (s_q.awaddr == fsp_pkg::ADDR_DBUF);
    // Rate ticks
    m2_tick = s_q.ctrl[fsp_pkg::B_MODE_HI] && !s_q.ctrl[fsp_pkg::B_MODE_LO] &&
              (s_q.mdiv == (s_q.aux[fsp_pkg::B_DBL] ? fsp_pkg::M2_DIV_FAST : fsp_pkg::M2_DIV_SLOW));
    t1_tick = i_tmr1_ovf && (s_q.aux[fsp_pkg::B_DBL] || s_q.half1);
    t2_tick = i_tmr2_ovf && (s_q.aux[fsp_pkg::B_DBL] || s_q.half2);
    rx_tick = (mode == fsp_pkg::MODE_U9F) ? m2_tick :
              (s_q.aux[fsp_pkg::B_RCS] ? t2_tick : t1_tick);
    tx_tick = (mode == fsp_pkg::MODE_U9F) ? m2_tick :
              (s_q.aux[fsp_pkg::B_TCS] ? t2_tick : t1_tick);
    tx_bit  = tx_tick && (s_q.tx_c16 == fsp_pkg::C16_LAST);
    tx_last = (mode == fsp_pkg::MODE_U8) ? fsp_pkg::IDX_LAST_U8 : fsp_pkg::IDX_LAST_U9;
    maj     = s_q.votes[1] || (s_q.votes[0] && rxd);
    rsr_sh  = {s_q.rsr[7:0], s_q.samp};

    // AXI write channel
    if (i_awvalid && s_q.awrdy) begin
      s_d.aw_hold = 1'b1;
      s_d.awaddr  = i_awaddr;
    end
    if (i_wvalid && s_q.wrdy) begin
      s_d.w_hold = 1'b1;
      s_d.wdata  = i_wdata[7:0];
      s_d.wstb   = i_wstrb[0];
    end
    if (wr_go) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = (s_q.awaddr == fsp_pkg::ADDR_CTRL || s_q.awaddr == fsp_pkg::ADDR_DBUF ||
                     s_q.awaddr == fsp_pkg::ADDR_AUX) ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
      if (wr_ctrl) begin
        s_d.ctrl = s_q.wdata;
      end
      if (s_q.wstb && s_q.awaddr == fsp_pkg::ADDR_AUX) begin
        s_d.aux = s_q.wdata[2:0];
      end
    end else if (s_q.bvalid && i_bready) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awrdy = !s_d.aw_hold;
    s_d.wrdy  = !s_d.w_hold;

    // AXI read channel
    if (i_arvalid && s_q.arrdy) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = fsp_pkg::RESP_OKAY;
      unique case (i_araddr)
        fsp_pkg::ADDR_CTRL: s_d.rdata = s_q.ctrl;
        fsp_pkg::ADDR_DBUF: s_d.rdata = s_q.rbuf;
        fsp_pkg::ADDR_AUX:  s_d.rdata = {2'h0, s_q.rx_st != fsp_pkg::RX_IDLE,
                                         s_q.tx_st != fsp_pkg::TX_IDLE, 1'b0, s_q.aux};
        default: begin
          s_d.rdata = 8'h00;
          s_d.rresp = fsp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && i_rready) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arrdy = !s_d.rvalid;

    // Machine cycle phase and rate dividers
    s_d.phase = (s_q.phase == fsp_pkg::PH_T12) ? fsp_pkg::PH_T1 : s_q.phase + 4'h1;
    s_d.mdiv  = m2_tick ? 2'h0 : s_q.mdiv + 2'h1;
    s_d.half1 = s_q.half1 ^ i_tmr1_ovf;
    s_d.half2 = s_q.half2 ^ i_tmr2_ovf;
    if (tx_tick) begin
      s_d.tx_c16 = s_q.tx_c16 + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    if (wr_dbuf) begin
      // Buffer write loads data and requests a frame in any mode
      s_d.tx_st = fsp_pkg::TX_ARM;
      s_d.m0w   = 1'b0;
      unique case (mode)
        fsp_pkg::MODE_SHIFT: s_d.tsr = {2'h1, s_q.wdata};
        fsp_pkg::MODE_U8:    s_d.tsr = {2'h1, s_q.wdata};
        default:             s_d.tsr = {1'b1, s_q.ctrl[fsp_pkg::B_TB8], s_q.wdata};
      endcase
    end else begin
      unique case (s_q.tx_st)
        fsp_pkg::TX_IDLE: ;
        fsp_pkg::TX_ARM: begin
          if (mode == fsp_pkg::MODE_SHIFT) begin
            // One full machine cycle passes before sending
            if (s_q.phase == fsp_pkg::PH_T1) begin
              s_d.m0w = 1'b1;
              if (s_q.m0w) begin
                s_d.tx_st = fsp_pkg::TX_SEND;
              end
            end
          end else if (tx_bit) begin
            s_d.tx_st  = fsp_pkg::TX_SEND;
            s_d.tx_idx = 4'h0;
          end
        end
        fsp_pkg::TX_SEND: begin
          if (mode == fsp_pkg::MODE_SHIFT) begin
            if (s_q.phase == fsp_pkg::PH_T12) begin
              s_d.tsr = {1'b0, s_q.tsr[9:1]};
              if (s_q.tsr[9:1] == fsp_pkg::TX0_DONE) begin
                s_d.tx_st = fsp_pkg::TX_FIN;
              end
            end
          end else if (tx_bit) begin
            if (s_q.tx_idx == tx_last) begin
              s_d.tx_st = fsp_pkg::TX_IDLE;
              s_d.ctrl[fsp_pkg::B_TI] = 1'b1;
            end else begin
              s_d.tx_idx = s_q.tx_idx + 4'h1;
              if (s_q.tx_idx != 4'h0) begin
                s_d.tsr = {1'b0, s_q.tsr[9:1]};
              end
            end
          end
        end
        fsp_pkg::TX_FIN: begin
          if (s_q.phase == fsp_pkg::PH_T1) begin
            s_d.tx_st = fsp_pkg::TX_IDLE;
            s_d.ctrl[fsp_pkg::B_TI] = 1'b1;
          end
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    if (rx_tick) begin
      s_d.rx_prev = rxd;
    end
    unique case (s_q.rx_st)
      fsp_pkg::RX_IDLE: begin
        if (s_q.ctrl[fsp_pkg::B_REN]) begin
          if (mode == fsp_pkg::MODE_SHIFT) begin
            if (!s_q.ctrl[fsp_pkg::B_RI]) begin
              s_d.rx_st = fsp_pkg::RX_ARM;
            end
          end else if (rx_tick && s_q.rx_prev && !rxd) begin
            s_d.rx_st  = fsp_pkg::RX_BUSY;
            s_d.rsr    = fsp_pkg::RXU_INIT;
            s_d.rx_c16 = 4'h0;
            s_d.rx_idx = 4'h0;
          end
        end
      end
      fsp_pkg::RX_ARM: begin
        if (mode != fsp_pkg::MODE_SHIFT || !s_q.ctrl[fsp_pkg::B_REN]) begin
          s_d.rx_st = fsp_pkg::RX_IDLE;
        end else if (s_q.phase == fsp_pkg::PH_T12) begin
          s_d.rsr   = fsp_pkg::RX0_INIT;
          s_d.rx_st = fsp_pkg::RX_BUSY;
        end
      end
      fsp_pkg::RX_BUSY: begin
        if (mode == fsp_pkg::MODE_SHIFT) begin
          if (s_q.phase == fsp_pkg::PH_T10) begin
            s_d.samp = rxd;
          end
          if (s_q.phase == fsp_pkg::PH_T12) begin
            s_d.rsr = rsr_sh;
            if (!s_q.rsr[7]) begin
              // Start zero lands on the left end with this shift
              s_d.rx_st = fsp_pkg::RX_IDLE;
              s_d.rbuf  = {<<{rsr_sh[7:0]}};    // First bit in is bit 0
              s_d.ctrl[fsp_pkg::B_RI] = 1'b1;
            end
          end
        end else if (rx_tick) begin
          s_d.rx_c16 = s_q.rx_c16 + 4'h1;
          if (s_q.rx_c16 == fsp_pkg::SAMP_A) begin
            s_d.votes = {1'b0, rxd};
          end else if (s_q.rx_c16 == fsp_pkg::SAMP_B) begin
            s_d.votes = s_q.votes + {1'b0, rxd};
          end else if (s_q.rx_c16 == fsp_pkg::SAMP_C) begin
            if (s_q.rx_idx == 4'h0) begin
              if (maj) begin
                s_d.rx_st = fsp_pkg::RX_IDLE;
              end
              s_d.rx_idx = 4'h1;
            end else begin
              s_d.rsr    = {maj, s_q.rsr[8:1]};
              s_d.rx_idx = s_q.rx_idx + 4'h1;
              if (s_q.rx_idx == fsp_pkg::IDX_RX_LAST) begin
                // Frame end: store only if flag clear and filter passes
                s_d.rx_st = fsp_pkg::RX_IDLE;
                if (!s_q.ctrl[fsp_pkg::B_RI] && (!s_q.ctrl[fsp_pkg::B_FILT] || maj)) begin
                  s_d.rbuf = s_q.rsr[8:1];
                  s_d.ctrl[fsp_pkg::B_RB8] = maj;
                  s_d.ctrl[fsp_pkg::B_RI]  = 1'b1;
                end
              end
            end
          end
        end
      end
      default: s_d.rx_st = fsp_pkg::RX_IDLE;
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Pin and interrupt outputs
    shclk = (s_d.phase >= fsp_pkg::PH_T11) || (s_d.phase <= fsp_pkg::PH_T4);
    if (mode == fsp_pkg::MODE_SHIFT) begin
      s_d.txd    = ((s_d.tx_st == fsp_pkg::TX_SEND) || (s_d.tx_st == fsp_pkg::TX_FIN) ||
                    (s_d.rx_st == fsp_pkg::RX_BUSY)) ? shclk : 1'b1;
      s_d.rxoe_n = !((s_d.tx_st == fsp_pkg::TX_SEND) || (s_d.tx_st == fsp_pkg::TX_FIN));
      s_d.rxo    = s_d.tsr[0];
    end else begin
      s_d.txd    = (s_d.tx_st != fsp_pkg::TX_SEND) ? 1'b1 :
                   ((s_d.tx_idx == 4'h0) ? 1'b0 : s_d.tsr[0]);
      s_d.rxoe_n = 1'b1;
      s_d.rxo    = 1'b1;
    end
    s_d.irq = s_q.ctrl[fsp_pkg::B_TI] || s_q.ctrl[fsp_pkg::B_RI];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q        <= '0;
      s_q.awrdy  <= 1'b1;
      s_q.wrdy   <= 1'b1;
      s_q.arrdy  <= 1'b1;
      s_q.ctrl   <= fsp_pkg::CTRL_RST;
      s_q.aux    <= fsp_pkg::AUX_RST;
      s_q.tx_st  <= fsp_pkg::TX_IDLE;
      s_q.rx_st  <= fsp_pkg::RX_IDLE;
      s_q.txd    <= 1'b1;
      s_q.rxo    <= 1'b1;
      s_q.rxoe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign o_awready                  = s_q.awrdy;
  assign o_wready                   = s_q.wrdy;
  assign o_bresp                    = s_q.bresp;
  assign o_bvalid                   = s_q.bvalid;
  assign o_arready                  = s_q.arrdy;
  assign o_rdata                    = {24'h000000, s_q.rdata};
  assign o_rresp                    = s_q.rresp;
  assign o_rvalid                   = s_q.rvalid;
  assign o_port_three_bit_one       = s_q.txd;
  assign o_port_three_bit_zero      = s_q.rxo;
  assign o_port_three_bit_zero_oe_n = s_q.rxoe_n;
  assign o_irq                      = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // Buffer only changes while the done flag was clear
  property p_buf_keep;
    $changed(s_q.rbuf) |-> !$past(s_q.ctrl[fsp_pkg::B_RI]);
  endproperty
  a_buf_keep: assert property (p_buf_keep) else $error("buffer overwritten while unread");

  // Final shift-mode stage sets the transmit flag on the next T1
  property p_ti_fin;
    (s_q.tx_st == fsp_pkg::TX_FIN && s_q.phase == fsp_pkg::PH_T1) |=> s_q.ctrl[fsp_pkg::B_TI];
  endproperty
  a_ti_fin: assert property (p_ti_fin) else $error("transmit flag not set");

  // Shift clock low in the middle phases while sending
  property p_shclk_low;
    (mode == fsp_pkg::MODE_SHIFT && s_q.tx_st == fsp_pkg::TX_SEND && s_q.phase == fsp_pkg::PH_T5)
      |-> !o_port_three_bit_one ##1 !o_port_three_bit_one;
  endproperty
  a_shclk_low: assert property (p_shclk_low) else $error("shift clock not low");

  // Shift receive loads its start pattern at T12
  property p_rx0_init;
    (s_q.rx_st == fsp_pkg::RX_ARM && mode == fsp_pkg::MODE_SHIFT && s_q.ctrl[fsp_pkg::B_REN] &&
     s_q.phase == fsp_pkg::PH_T12) |=> (s_q.rsr == fsp_pkg::RX0_INIT && s_q.rx_st == fsp_pkg::RX_BUSY);
  endproperty
  a_rx0_init: assert property (p_rx0_init) else $error("shift receive start wrong");

  // Falling edge loads all ones and restarts the counter
  property p_edge_load;
    (s_q.rx_st == fsp_pkg::RX_IDLE && mode != fsp_pkg::MODE_SHIFT && s_q.ctrl[fsp_pkg::B_REN] &&
     rx_tick && s_q.rx_prev && !rxd) |=> (s_q.rsr == fsp_pkg::RXU_INIT && s_q.rx_c16 == 4'h0);
  endproperty
  a_edge_load: assert property (p_edge_load) else $error("start edge not taken");

  // Filtered frame never raises the done flag with ninth bit low
  property p_filter;
    ($rose(s_q.ctrl[fsp_pkg::B_RI]) && !$past(wr_ctrl) && mode != fsp_pkg::MODE_SHIFT &&
     s_q.ctrl[fsp_pkg::B_FILT]) |-> s_q.ctrl[fsp_pkg::B_RB8];
  endproperty
  a_filter: assert property (p_filter) else $error("filter let frame through");

  // Disabled receiver stays idle
  property p_ren_off;
    (s_q.rx_st == fsp_pkg::RX_IDLE && !s_q.ctrl[fsp_pkg::B_REN]) |=> s_q.rx_st == fsp_pkg::RX_IDLE;
  endproperty
  a_ren_off: assert property (p_ren_off) else $error("receiver started while disabled");

  // Shift-mode send begins one to two machine cycles after the write
  property p_tx0_start;
    (wr_dbuf && mode == fsp_pkg::MODE_SHIFT) |=> s_q.tx_st == fsp_pkg::TX_ARM ##[12:25]
      s_q.tx_st == fsp_pkg::TX_SEND;
  endproperty
  a_tx0_start: assert property (p_tx0_start) else $error("shift send start late");

  // Interrupt request follows a set flag
  property p_irq;
    $rose(s_q.ctrl[fsp_pkg::B_RI]) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing");

  // Main scenarios
  c_tx0_done: cover property (s_q.tx_st == fsp_pkg::TX_FIN ##1 s_q.tx_st == fsp_pkg::TX_IDLE);
  c_uart_rx: cover property (mode == fsp_pkg::MODE_U8 && $rose(s_q.ctrl[fsp_pkg::B_RI]));
  c_false_start: cover property (s_q.rx_st == fsp_pkg::RX_BUSY && rx_tick && s_q.rx_c16 == fsp_pkg::SAMP_C
                                 && s_q.rx_idx == 4'h0 && maj);
  c_uart_tx: cover property (mode == fsp_pkg::MODE_U9V && $rose(s_q.ctrl[fsp_pkg::B_TI]));

endmodule
`default_nettype wire

// >>> verif/fsp_peer.sv
// Remote serial peer: sends 9-bit frames, captures and feeds shift-mode data.
// Assumes the bench resolves the shared data pin; the line idles high (pull-up).
`timescale 1ns/1ps
`default_nettype none
module fsp_peer (
  // Clock and pins
  input  wire logic       i_clk,
  input  wire logic       i_sclk,
  input  wire logic       i_data,
  input  wire logic       i_oe_n,
  output logic            o_line,
  output logic [7:0]      o_cap
);
  logic       sclk_q = 1'b1;
  logic       uart_q = 1'b1;
  logic       shf_q  = 1'b1;
  logic [7:0] src    = 8'hFF;
  // Both sources idle high, so the line is their AND
  assign o_line = uart_q && shf_q;
  // Start low, eight data LSB first, ninth bit, stop high; 64 clocks a bit
  task automatic send(input logic [8:0] d);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    @(posedge i_clk);
    for (int i = 0; i < 11; i++) begin
      uart_q <= f[i];
      repeat (64) @(posedge i_clk);
    end
  endtask
  // Byte to feed LSB first on the next shift-mode receive
  task automatic load(input logic [7:0] d);
    src <= d;
  endtask
  // Shift-mode capture on rising clock while driven; feed on falling clock while released
  always @(posedge i_clk) begin
    sclk_q <= i_sclk;
    if (!sclk_q && i_sclk && !i_oe_n) o_cap <= {i_data, o_cap[7:1]};
    else if (sclk_q && !i_sclk && i_oe_n) begin
      shf_q <= src[0];
      src   <= {1'b1, src[7:1]};
    end
  end
endmodule
`default_nettype wire

// >>> verif/fsp_serial_port_tb.sv
// Self-checking bench for the four-mode serial port over AXI4-Lite.
// Assumes a 100 MHz clock; timer strobes pulse at two rates, all four modes used.
`timescale 1ns/1ps
`default_nettype none
module fsp_serial_port_tb;
  logic clk, rst_n, awv, wv, bre, arv, rre, line, rx_pin;
  logic [7:0] awa, ara, cap;
  logic [31:0] wd, rd_d, rdata;
  logic [3:0] wst;
  logic [1:0] br, rr, bresp, rresp;
  logic awr, wr_r, bv, arr, rv, d0, oe_n, d1, irq;
  int num_errors, checked;
  logic t1o, t2o;
  int cyc;
  assign rx_pin = oe_n ? line : d0;
  fsp_serial_port dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(wst), .i_wvalid(wv), .o_wready(wr_r), .o_bresp(bresp),
    .o_bvalid(bv), .i_bready(bre), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rv), .i_rready(rre), .i_tmr1_ovf(t1o), .i_tmr2_ovf(t2o),
    .i_port_three_bit_zero(rx_pin), .o_port_three_bit_zero(d0), .o_port_three_bit_zero_oe_n(oe_n),
    .o_port_three_bit_one(d1), .o_irq(irq));
  fsp_peer peer_u (.i_clk(clk), .i_sclk(d1), .i_data(rx_pin), .i_oe_n(oe_n), .o_line(line), .o_cap(cap));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Timer strobes: first timer every second clock, second timer every fourth
  always @(posedge clk) begin
    cyc <= cyc + 1;
    t1o <= cyc[0];
    t2o <= (cyc[1:0] == 2'h3);
  end
  // Register write; handshake flags sampled on the falling edge before each take
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awa <= a; wd <= {24'h000000, d}; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    do begin
      @(negedge clk); ta = awr; tw = wr_r; tb = bv; br = bresp;
      @(posedge clk); if (ta) awv <= 1'b0; if (tw) wv <= 1'b0;
    end while (!tb);
    bre <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic tv, ta;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do begin
      @(negedge clk); tv = rv; ta = arr; rd_d = rdata; rr = rresp;
      @(posedge clk); if (ta) arv <= 1'b0;
    end while (!tv);
    rre <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, several times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end
  initial begin
    num_errors = 0; checked = 0; rst_n = 1'b0; awv = 1'b0; wv = 1'b0; bre = 1'b0;
    cyc = 0;
    arv = 1'b0; rre = 1'b0; awa = 8'h00; ara = 8'h00; wd = 32'h00000000; wst = 4'hF;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(fsp_pkg::ADDR_CTRL); chk("ctrl reset", 32'h00000000, rd_d);
    rd(8'hA4); chk("unmapped resp", {30'h0, fsp_pkg::RESP_SLVERR}, {30'h0, rr});
    wr(8'hA4, 8'hFF); chk("unmapped wresp", {30'h0, fsp_pkg::RESP_SLVERR}, {30'h0, br});
    $display("test reset done");
    // Fixed-rate 9-bit receive, then a frame refused while the flag is set
    wr(fsp_pkg::ADDR_CTRL, 8'h90);
    peer_u.send(9'h1A5);
    repeat (100) @(posedge clk);
    rd(fsp_pkg::ADDR_DBUF); chk("rx byte", 32'h000000A5, rd_d);
    rd(fsp_pkg::ADDR_CTRL); chk("rx flags", 32'h00000095, rd_d);
    chk("irq", 32'h1, {31'h0, irq});
    peer_u.send(9'h15A);
    repeat (100) @(posedge clk);
    rd(fsp_pkg::ADDR_DBUF); chk("refused frame", 32'h000000A5, rd_d);
    $display("test receive done");
    // Address filter drops ninth bit 0, accepts ninth bit 1
    wr(fsp_pkg::ADDR_CTRL, 8'hB0);
    peer_u.send(9'h03C);
    repeat (100) @(posedge clk);
    rd(fsp_pkg::ADDR_CTRL); chk("filter drop", 32'h000000B0, rd_d);
    peer_u.send(9'h1C3);
    repeat (100) @(posedge clk);
    rd(fsp_pkg::ADDR_CTRL); chk("filter pass", 32'h000000B5, rd_d);
    rd(fsp_pkg::ADDR_DBUF); chk("filter byte", 32'h000000C3, rd_d);
    $display("test filter done");
    // Strobe 0 clear leaves control alone; then variable rate from the second timer, doubled
    wst <= 4'h0;
    wr(fsp_pkg::ADDR_CTRL, 8'h00); chk("strobe off resp", {30'h0, fsp_pkg::RESP_OKAY}, {30'h0, br});
    wst <= 4'hF;
    rd(fsp_pkg::ADDR_CTRL); chk("strobe off keep", 32'h000000B5, rd_d);
    wr(fsp_pkg::ADDR_AUX, 8'h03);
    rd(fsp_pkg::ADDR_AUX); chk("aux", 32'h00000003, rd_d);
    wr(fsp_pkg::ADDR_CTRL, 8'hD0);
    peer_u.send(9'h0E7);
    repeat (100) @(posedge clk);
    rd(fsp_pkg::ADDR_DBUF); chk("mode3 byte", 32'h000000E7, rd_d);
    rd(fsp_pkg::ADDR_CTRL); chk("mode3 flags", 32'h000000D1, rd_d);
    wr(fsp_pkg::ADDR_CTRL, 8'h70);
    peer_u.send(9'h0A5);
    repeat (100) @(posedge clk);
    rd(fsp_pkg::ADDR_CTRL); chk("bad stop", 32'h00000070, rd_d);
    peer_u.send(9'h15A);
    repeat (100) @(posedge clk);
    rd(fsp_pkg::ADDR_CTRL); chk("mode1 flags", 32'h00000075, rd_d);
    rd(fsp_pkg::ADDR_DBUF); chk("mode1 byte", 32'h0000005A, rd_d);
    $display("test variable rate done");
    // Shift-mode transmit, eight bits LSB first then done flag
    wr(fsp_pkg::ADDR_CTRL, 8'h00);
    wr(fsp_pkg::ADDR_DBUF, 8'h3C);
    repeat (160) @(posedge clk);
    rd(fsp_pkg::ADDR_CTRL); chk("tx done", 32'h00000002, rd_d);
    chk("shift data", 32'h0000003C, {24'h0, cap});
    $display("test shift done");
    // Shift-mode receive, started by enable with the done flag clear
    peer_u.load(8'h2D);
    wr(fsp_pkg::ADDR_CTRL, 8'h10);
    repeat (160) @(posedge clk);
    rd(fsp_pkg::ADDR_DBUF); chk("shift rx byte", 32'h0000002D, rd_d);
    rd(fsp_pkg::ADDR_CTRL); chk("shift rx flags", 32'h00000011, rd_d);
    $display("test shift receive done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
